// *** verilog/tmr_consts.svh ***
// Timing constants and counter widths for the triple timer unit
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_WIDTH      16
`define TMR_SVC_PERIOD 4
`define TMR_IN_LAT     6
`define TMR_OUT_LAT    6
`define TMR_CNT_RST    16'h0000
`define TMR_PIN_IDLE   1'b1
`endif

// *** verilog/tmr_pkg.sv ***
// Types shared by the triple timer unit
package tmr_pkg;
  typedef logic [15:0] count_t;
  typedef enum logic [1:0] {
    CLK_INTERNAL = 2'h0,
    CLK_EXTERNAL = 2'h1,
    CLK_PRESCALE = 2'h2
  } clk_src_t;
endpackage

// *** verilog/timer_core.sv ***
// One 16-bit timer channel with optional second maximum count
`timescale 1ns/1ps
module timer_core (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        enable,
  input  wire logic        tick,
  input  wire logic        dual_en,
  input  wire logic [15:0] max_a,
  input  wire logic [15:0] max_b,
  output logic             wrap_q,
  output logic             use_b_q,
  output logic [15:0]      count_q
);
  `include "tmr_consts.svh"
  logic at_max;
  assign at_max = (count_q == (use_b_q ? max_b : max_a));

  // Counter restarts after reaching the active maximum
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q <= `TMR_CNT_RST;
    end else if (ce && enable && tick) begin
      count_q <= at_max ? `TMR_CNT_RST : count_q + 16'h0001; // [RULE1] [RULE11]
    end
  end

  // Alternate between maxima; also marks the output level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      use_b_q <= 1'b0;
    end else if (ce) begin
      if (!dual_en) begin
        use_b_q <= 1'b0;
      end else if (enable && tick && at_max) begin
        use_b_q <= ~use_b_q; // [RULE12] [RULE13]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrap_q <= 1'b0;
    end else if (ce) begin
      wrap_q <= enable && tick && at_max;
    end
  end
endmodule // timer_core

// *** verilog/triple_timer_pwm_unit.sv ***
// Triple 16-bit timer unit with two pin timers and one internal prescaler
// Function
// [RULE1] Three independent timers, each 16-bit counter
// [RULE2] Timers A and B have in and out pins
// [RULE3] A and B count or time input events
// [RULE4] A and B drive single-shot or duty waveforms
// [RULE5] Timer C internal only, no pins
// [RULE6] Timer C can prescale timer A or B
// [RULE7] Timer C may raise a DMA request
// [RULE8] Each timer serviced every fourth clock
// [RULE9] Input events act within six clocks
// [RULE10] Output changes within six clocks of event
// [RULE11] Active maximum count ends each count cycle
// [RULE12] A and B alternate primary and secondary maxima
// [RULE13] Dual mode output level shows active maximum
// [RULE14] Input pins synchronised before edge detection
`timescale 1ns/1ps
module triple_timer_pwm_unit
  import tmr_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  input  wire logic [2:0]       tmr_enable,
  input  wire tmr_pkg::clk_src_t a_src,
  input  wire tmr_pkg::clk_src_t b_src,
  input  wire logic             a_dual,
  input  wire logic             b_dual,
  input  wire logic             a_cont,
  input  wire logic             b_cont,
  input  wire logic             c_dma_en,
  input  wire tmr_pkg::count_t  a_max_a,
  input  wire tmr_pkg::count_t  a_max_b,
  input  wire tmr_pkg::count_t  b_max_a,
  input  wire tmr_pkg::count_t  b_max_b,
  input  wire tmr_pkg::count_t  c_max,
  input  wire logic             timer_a_in_pin,
  input  wire logic             timer_b_in_pin,
  output logic                  timer_a_out_pin,
  output logic                  timer_b_out_pin,
  output logic                  c_dma_req_q,
  output tmr_pkg::count_t       a_count,
  output tmr_pkg::count_t       b_count,
  output tmr_pkg::count_t       c_count
);
  import tmr_pkg::*;
  `include "tmr_consts.svh"

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  logic [1:0] sa_q, sb_q;
  logic       pa_q, pb_q;
  logic       edge_a_q, edge_b_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Pins idle high on pull-ups; a low reset value would fake an edge
      sa_q <= {2{`TMR_PIN_IDLE}};
      sb_q <= {2{`TMR_PIN_IDLE}};
      pa_q <= `TMR_PIN_IDLE;
      pb_q <= `TMR_PIN_IDLE;
    end else if (ce) begin
      sa_q <= {sa_q[0], timer_a_in_pin}; // [RULE14]
      sb_q <= {sb_q[0], timer_b_in_pin}; // [RULE14]
      pa_q <= sa_q[1];
      pb_q <= sb_q[1];
    end
  end

  // Edges held until the next service slot so none is lost
  logic [1:0] slot_q;
  logic       slot_a, slot_b, slot_c;
  assign slot_a = (slot_q == 2'h0);
  assign slot_b = (slot_q == 2'h1);
  assign slot_c = (slot_q == 2'h2);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      edge_a_q <= 1'b0;
      edge_b_q <= 1'b0;
    end else if (ce) begin
      edge_a_q <= (sa_q[1] & ~pa_q) | (edge_a_q & ~slot_a); // [RULE3] [RULE9]
      edge_b_q <= (sb_q[1] & ~pb_q) | (edge_b_q & ~slot_b); // [RULE3] [RULE9]
    end
  end

  // ****************************************
  // Service slot rotation
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slot_q <= 2'h0;
    end else if (ce) begin
      slot_q <= slot_q + 2'h1; // [RULE8]
    end
  end

  // ****************************************
  // Timer C, prescaler and DMA source
  // ****************************************
  logic c_wrap, c_pend_a_q, c_pend_b_q;
  timer_core u_c (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .enable  (tmr_enable[2]),
    .tick    (slot_c),
    .dual_en (1'b0),
    .max_a   (c_max),
    .max_b   (c_max),
    .wrap_q  (c_wrap),
    .use_b_q (),
    .count_q (c_count)
  ); // [RULE5]

  // Wrap events wait for the consumer's slot
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      c_pend_a_q <= 1'b0;
      c_pend_b_q <= 1'b0;
      c_dma_req_q <= 1'b0;
    end else if (ce) begin
      c_pend_a_q <= c_wrap | (c_pend_a_q & ~slot_a); // [RULE6]
      c_pend_b_q <= c_wrap | (c_pend_b_q & ~slot_b); // [RULE6]
      c_dma_req_q <= c_dma_en & c_wrap; // [RULE7]
    end
  end

  // ****************************************
  // Timers A and B
  // ****************************************
  function automatic logic pick(clk_src_t s, logic ext, logic pre);
    case (s)
      CLK_INTERNAL: pick = 1'b1;
      CLK_EXTERNAL: pick = ext;
      CLK_PRESCALE: pick = pre;
      default:      pick = 1'b0;
    endcase
  endfunction

  logic a_tick, b_tick, a_wrap, b_wrap, a_useb, b_useb;
  logic a_done_q, b_done_q;
  assign a_tick = slot_a & pick(a_src, edge_a_q, c_pend_a_q);
  assign b_tick = slot_b & pick(b_src, edge_b_q, c_pend_b_q);

  timer_core u_a (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .enable  (tmr_enable[0] & ~a_done_q),
    .tick    (a_tick),
    .dual_en (a_dual),
    .max_a   (a_max_a),
    .max_b   (a_max_b),
    .wrap_q  (a_wrap),
    .use_b_q (a_useb),
    .count_q (a_count)
  ); // [RULE1] [RULE2]

  timer_core u_b (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .enable  (tmr_enable[1] & ~b_done_q),
    .tick    (b_tick),
    .dual_en (b_dual),
    .max_a   (b_max_a),
    .max_b   (b_max_b),
    .wrap_q  (b_wrap),
    .use_b_q (b_useb),
    .count_q (b_count)
  ); // [RULE1] [RULE2]

  // Single-shot stops after one full cycle; clearing enable rearms it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_done_q <= 1'b0;
      b_done_q <= 1'b0;
    end else if (ce) begin
      if (!tmr_enable[0]) a_done_q <= 1'b0;
      else if (a_wrap && !a_cont && (!a_dual || !a_useb)) a_done_q <= 1'b1; // [RULE4]
      if (!tmr_enable[1]) b_done_q <= 1'b0;
      else if (b_wrap && !b_cont && (!b_dual || !b_useb)) b_done_q <= 1'b1; // [RULE4]
    end
  end

  // Dual mode: level shows active maximum; single mode: one-clock low pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_a_out_pin <= 1'b1;
      timer_b_out_pin <= 1'b1;
    end else if (ce) begin
      timer_a_out_pin <= a_dual ? ~a_useb : ~a_wrap; // [RULE4] [RULE10] [RULE13]
      timer_b_out_pin <= b_dual ? ~b_useb : ~b_wrap; // [RULE4] [RULE10] [RULE13]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_slot_rotate: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
    ce |=> (slot_q == $past(slot_q) + 2'h1)) else $error("slot not rotating");
  chk_sync_path: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
    ce ##1 ce |-> (sa_q[1] == $past(sa_q[0]))) else $error("sync stage wrong");
  chk_a_edge_real: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
    $rose(edge_a_q) && $past(ce) && $past(ce, 2) |-> $past(sa_q[1]) && !$past(sa_q[1], 2))
    else $error("a edge without pin rise");
  chk_a_single_tick: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
    $changed(a_count) |-> $past(slot_a)) else $error("timer a moved off slot");
  chk_b_single_tick: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
    $changed(b_count) |-> $past(slot_b)) else $error("timer b moved off slot");
  chk_dma_cause: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
    c_dma_req_q |-> $past(c_wrap) && $past(c_dma_en)) else $error("stray dma");
  chk_dma_follows: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
    ce && c_dma_en && c_wrap |=> c_dma_req_q) else $error("dma request missing");
  chk_a_dual_level: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
    ce && a_dual |=> timer_a_out_pin == ~$past(a_useb)) else $error("a level");
  chk_b_dual_level: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
    ce && b_dual |=> timer_b_out_pin == ~$past(b_useb)) else $error("b level");
  // Single mode: a wrap must show as a low pin on the next clock
  sequence s_a_wrap_single;
    ce && !a_dual && a_wrap;
  endsequence
  chk_a_wrap_pulse: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4] [RULE10]
    s_a_wrap_single |=> !timer_a_out_pin) else $error("a wrap pulse missing");
  chk_c_wrap_counts: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
    c_wrap |-> c_count == 16'h0000) else $error("c wrap not at zero");
  chk_a_max_bound: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
    !a_dual && a_count <= a_max_a && $stable(a_max_a) |=> a_count <= a_max_a)
    else $error("a over max");
endmodule // triple_timer_pwm_unit

// *** tb/event_src.sv ***
// External event source standing in on one timer input pin
`timescale 1ns/1ps
module event_src (
  input  wire logic clk,
  input  wire logic fire,
  output logic      pin
);
  // Line has a pull-up, so it idles high; edges land off the clock grid
  initial pin = 1'b1;
  always @(posedge fire) begin
    #7 pin = 1'b0;
    repeat (3) @(posedge clk);
    #11 pin = 1'b1;
  end
endmodule // event_src

// *** tb/tb_top.sv ***
// Self-checking bench for the triple timer unit
`timescale 1ns/1ps
module tb_top
  import tmr_pkg::*;
;
  typedef struct {logic s; logic dual; count_t ma; count_t mb; int lo; int hi;} row_t;
  logic clk = 0, sys_rst = 1, ce = 1, a_dual = 0, b_dual = 0, a_cont = 1, b_cont = 1;
  logic c_dma_en = 0, fire_a = 0, fire_b = 0, a_in, b_in, a_out, b_out, dma;
  logic [2:0] tmr_enable = 3'h0;
  clk_src_t a_src = CLK_INTERNAL, b_src = CLK_INTERNAL;
  count_t a_max_a = 16'h0003, a_max_b = 16'h0003, b_max_a = 16'h0003, b_max_b = 16'h0003;
  count_t c_max = 16'h0001, a_count, b_count, c_count;
  int fail_count = 0, n_tests = 0, lo, hi, n, k;
  row_t r;
  // Row: timer B select, dual mode, maxima, expected low and high widths in clocks
  row_t rows[4] = '{'{0, 0, 16'h0003, 16'h0000, 1, 15},
                    '{0, 1, 16'h0002, 16'h0005, 24, 12},
                    '{1, 1, 16'h0000, 16'h0001, 8, 4},
                    '{1, 0, 16'h0009, 16'h0000, 1, 39}};
  always #20 clk = ~clk;
  event_src i_src_a (.clk(clk), .fire(fire_a), .pin(a_in));
  event_src i_src_b (.clk(clk), .fire(fire_b), .pin(b_in));
  triple_timer_pwm_unit i_triple_timer_pwm_unit (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .tmr_enable(tmr_enable), .a_src(a_src), .b_src(b_src), .a_dual(a_dual),
    .b_dual(b_dual), .a_cont(a_cont), .b_cont(b_cont), .c_dma_en(c_dma_en),
    .a_max_a(a_max_a), .a_max_b(a_max_b), .b_max_a(b_max_a), .b_max_b(b_max_b),
    .c_max(c_max), .timer_a_in_pin(a_in), .timer_b_in_pin(b_in),
    .timer_a_out_pin(a_out), .timer_b_out_pin(b_out), .c_dma_req_q(dma),
    .a_count(a_count), .b_count(b_count), .c_count(c_count));
  task automatic cyc(input int m);
    repeat (m) @(negedge clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wait_lvl(input logic s, input logic lv, output int m);
    m = 0;
    while ((s ? b_out : a_out) !== lv) begin
      cyc(1);
      m++;
      if (m > 5000) begin
        check(0, 1);
        final_report();
      end
    end
  endtask
  task automatic rst();
    sys_rst = 1;
    cyc(6);
    sys_rst = 0;
  endtask
  // ****************
  // Stimulus
  // ****************
  initial begin
    rst();
    check({a_count, b_count}, 0);
    check({a_out, b_out, dma}, 3'h6);
    $display("reset test done");
    // Reset before each row so every output starts on the primary phase
    foreach (rows[i]) begin
      r = rows[i];
      {a_dual, a_max_a, a_max_b} = {r.dual, r.ma, r.mb};
      {b_dual, b_max_a, b_max_b} = {r.dual, r.ma, r.mb};
      rst();
      tmr_enable = r.s ? 3'h2 : 3'h1;
      wait_lvl(r.s, 0, n);
      wait_lvl(r.s, 1, lo);
      wait_lvl(r.s, 0, hi);
      check(lo, r.lo);
      check(hi, r.hi);
      $display("row %0d done", i);
    end
    {a_dual, b_dual, a_max_a, b_max_a} = {2'h0, 16'h00FF, 16'h00FF};
    a_src = CLK_EXTERNAL;
    b_src = CLK_EXTERNAL;
    rst();
    tmr_enable = 3'h3;
    for (k = 0; k < 6; k++) begin
      fire_a = k < 5;
      fire_b = 1;
      cyc(1);
      {fire_a, fire_b} = 2'h0;
      cyc(12);
    end
    check(a_count, 5);
    check(b_count, 6);
    tmr_enable = 3'h0;
    fire_a = 1;
    cyc(14);
    fire_a = 0;
    check(a_count, 5);
    $display("event test done");
    a_src = CLK_PRESCALE;
    b_src = CLK_PRESCALE;
    c_dma_en = 1'b1;
    rst();
    tmr_enable = 3'h7;
    n = 0;
    repeat (160) begin
      cyc(1);
      n += dma;
    end
    // Timer C ticks once more, 0 to 1, before it is stopped
    cyc(4);
    check(c_count, 1);
    tmr_enable = 3'h3;
    cyc(12);
    check(a_count, 20);
    check(b_count, 20);
    check(n, 20);
    $display("prescale test done");
    a_src = CLK_INTERNAL;
    {a_cont, a_max_a} = {1'b0, 16'h0002};
    rst();
    tmr_enable = 3'h1;
    n = 0;
    repeat (100) begin
      cyc(1);
      n += !a_out;
    end
    check(n, 1);
    $display("single shot test done");
    final_report();
  end
endmodule // tb_top
